/* design/aoc_ctrl.sv */
// Purpose: digital output side of a 12-bit pipelined sampling converter
// Assumes: strobe slower than clock / 2; straps static in operation
// Notes:   enables are active low (low = pin driven)
`timescale 1ns/10ps
module aoc_ctrl
  import aoc_pkg::*;
#(
  parameter int LATENCY = AOC_LATENCY
) (
  input  wire logic                  clock,
  input  wire logic                  arst_n,
  input  wire logic                  clk_en,
  input  wire logic                  sample_strobe_p,
  input  wire logic                  sample_strobe_n,
  input  wire logic                  power_down_select,
  input  wire logic                  drive_gate,
  input  wire logic [1:0]            style_strap,
  input  wire logic [1:0]            format_strap,
  input  wire logic [AOC_WORD_W-1:0] sample_word,
  input  wire logic                  sample_over_range,
  output logic      [AOC_WORD_W-1:0] first_bus_word,
  output logic                       first_bus_word_oe_n,
  output logic                       first_bus_range_flag,
  output logic                       first_bus_valid_strobe,
  output logic                       first_bus_oe_n,
  output logic      [AOC_WORD_W-1:0] second_bus_word,
  output logic                       second_bus_range_flag,
  output logic                       second_bus_valid_strobe,
  output logic                       second_bus_word_oe_n,
  output logic                       second_bus_strobe_oe_n,
  output logic      [AOC_WORD_W-1:0] diff_data_word,
  output logic                       diff_range_flag,
  output logic                       diff_valid_strobe,
  output logic                       diff_oe_n,
  output logic                       stabiliser_on,
  output logic                       converting
);
  localparam int SW = 6;
  logic [SW-1:0] sync_out;
  logic          enc_reg;
  logic          strobe_rise;
  logic [AOC_WORD_W:0] pipe_reg [LATENCY];
  logic [AOC_WORD_W:0] result;
  logic          phase_reg;
  aoc_style_type style;
  aoc_power_type power;
  logic          twos_fmt;
  logic          run;
  logic          drive;
  logic [AOC_WORD_W-1:0] coded;

  // Sample word is converter-internal, same domain; only pins synchronised
  aoc_sync #(.WIDTH(SW)) u_sync (
    .clock    (clock),
    .arst_n   (arst_n),
    .clk_en   (clk_en),
    .async_in ({sample_strobe_p & ~sample_strobe_n, power_down_select,
                drive_gate, style_strap[1], style_strap[0],
                format_strap[1]}),
    .sync_out (sync_out)
  );

  logic fmt0_meta_reg;
  logic fmt0_reg;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fmt0_meta_reg <= 1'b0;
      fmt0_reg      <= 1'b0;
    end else if (clk_en) begin
      fmt0_meta_reg <= format_strap[0];
      fmt0_reg      <= fmt0_meta_reg;
    end
  end

  function automatic aoc_style_type style_of(input logic [1:0] lvl);
    unique case (lvl)
      AOC_LVL_GND:   style_of = AOC_STYLE_FULL;
      AOC_LVL_THIRD: style_of = AOC_STYLE_SIMUL;
      AOC_LVL_TWO3:  style_of = AOC_STYLE_INTLV;
      AOC_LVL_FULL:  style_of = AOC_STYLE_LVDS;
    endcase
  endfunction : style_of

  always_comb begin
    style    = style_of(sync_out[2:1]);
    power    = aoc_power_type'({sync_out[4], sync_out[3]});
    // Both format codes above one third are two's complement
    twos_fmt = sync_out[0];
    run      = (power == AOC_PWR_RUN) || (power == AOC_PWR_HIZ);
    drive    = (power == AOC_PWR_RUN);
    strobe_rise = sync_out[5] & ~enc_reg;
    result   = pipe_reg[LATENCY-1];
    // Offset binary differs from two's complement in the MSB only
    coded    = twos_fmt ? result[AOC_WORD_W-1:0]
             : {~result[AOC_MSB], result[AOC_MSB-1:0]};
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      enc_reg <= 1'b0;
    end else if (clk_en) begin
      enc_reg <= sync_out[5];
    end
  end

  // Pipeline advances one stage per strobe; nap and sleep freeze it
  // Head and tail split at elaboration so no stage indexes below zero
  genvar g;
  generate
    for (g = 0; g < LATENCY; g++) begin : g_pipe
      if (g == 0) begin : g_head
        always_ff @(posedge clock or negedge arst_n) begin
          if (!arst_n) begin
            pipe_reg[g] <= '0;
          end else if (clk_en && run && strobe_rise) begin
            pipe_reg[g] <= {sample_over_range, sample_word};
          end
        end
      end else begin : g_tail
        always_ff @(posedge clock or negedge arst_n) begin
          if (!arst_n) begin
            pipe_reg[g] <= '0;
          end else if (clk_en && run && strobe_rise) begin
            pipe_reg[g] <= pipe_reg[g-1];
          end
        end
      end
    end
  endgenerate

  // Output registers and strobes
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      first_bus_word          <= AOC_WORD_RST;
      first_bus_range_flag    <= 1'b0;
      first_bus_valid_strobe  <= 1'b0;
      second_bus_word         <= AOC_WORD_RST;
      second_bus_range_flag   <= 1'b0;
      second_bus_valid_strobe <= 1'b0;
      diff_data_word          <= AOC_WORD_RST;
      diff_range_flag         <= 1'b0;
      diff_valid_strobe       <= 1'b0;
      phase_reg               <= 1'b0;
    end else if (clk_en && run) begin
      if (strobe_rise) begin
        unique case (style)
          AOC_STYLE_FULL: begin
            first_bus_word         <= coded;
            first_bus_range_flag   <= result[AOC_WORD_W];
            first_bus_valid_strobe <= 1'b1;
            second_bus_valid_strobe <= 1'b1;
          end
          AOC_STYLE_LVDS: begin
            diff_data_word    <= coded;
            diff_range_flag   <= result[AOC_WORD_W];
            diff_valid_strobe <= 1'b1;
          end
          default: begin
            phase_reg <= ~phase_reg;
            if (!phase_reg) begin
              first_bus_word         <= coded;
              first_bus_range_flag   <= result[AOC_WORD_W];
              first_bus_valid_strobe <= 1'b1;
              // Second strobe falls as the first bus takes its word
              second_bus_valid_strobe <= 1'b0;
            end else begin
              second_bus_word       <= coded;
              second_bus_range_flag <= result[AOC_WORD_W];
              first_bus_valid_strobe <= 1'b0;
              // Simultaneous rise waits half a sample for setup
              if (style == AOC_STYLE_INTLV) begin
                second_bus_valid_strobe <= 1'b1;
              end
            end
          end
        endcase
      end else if (!sync_out[5] && enc_reg) begin
        // Falling strobe edge: full rate and LVDS strobes drop
        if (style == AOC_STYLE_FULL) begin
          first_bus_valid_strobe  <= 1'b0;
          second_bus_valid_strobe <= 1'b0;
        end
        if (style == AOC_STYLE_LVDS) begin
          diff_valid_strobe <= 1'b0;
        end
        // Rising mid-word, a rising-edge latch never sees the word move
        if (style == AOC_STYLE_SIMUL && !phase_reg) begin
          second_bus_valid_strobe <= 1'b1;
        end
      end
    end
  end

  // Drive enables, low while the pin is driven
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      first_bus_word_oe_n    <= 1'b1;
      first_bus_oe_n         <= 1'b1;
      second_bus_word_oe_n   <= 1'b1;
      second_bus_strobe_oe_n <= 1'b1;
      diff_oe_n              <= 1'b1;
      stabiliser_on          <= 1'b0;
      converting             <= 1'b0;
    end else if (clk_en) begin
      first_bus_word_oe_n    <= !(drive && style != AOC_STYLE_LVDS);
      first_bus_oe_n         <= !(drive && style != AOC_STYLE_LVDS);
      second_bus_word_oe_n   <= !(drive && (style == AOC_STYLE_SIMUL ||
                                 style == AOC_STYLE_INTLV));
      second_bus_strobe_oe_n <= !(drive && style != AOC_STYLE_LVDS);
      diff_oe_n              <= !(drive && style == AOC_STYLE_LVDS);
      stabiliser_on          <= sync_out[0] ^ fmt0_reg;
      converting             <= run;
    end
  end

  AST_FULL_HIZ: assert property (@(posedge clock)
    disable iff (!arst_n)
    clk_en && style == AOC_STYLE_FULL |=> second_bus_word_oe_n)
    else $error("second bus driven in full-rate style");
  AST_STROBE_DRIVEN: assert property (@(posedge clock)
    disable iff (!arst_n)
    clk_en && drive && style == AOC_STYLE_FULL |=> !second_bus_strobe_oe_n)
    else $error("second strobe not driven in full-rate style");
  AST_POWER_HIZ: assert property (@(posedge clock)
    disable iff (!arst_n)
    clk_en && !drive |=> first_bus_oe_n && diff_oe_n && second_bus_word_oe_n)
    else $error("outputs driven while gated or powered down");
  AST_NAP_FREEZE: assert property (@(posedge clock)
    disable iff (!arst_n)
    clk_en && !run |=> $stable(first_bus_word))
    else $error("bus changed in nap or sleep");
  AST_FULL_WORD: assert property (@(posedge clock)
    disable iff (!arst_n)
    clk_en && run && strobe_rise && style == AOC_STYLE_FULL
    |=> first_bus_range_flag == $past(result[AOC_WORD_W]))
    else $error("range flag not carried with word");
  AST_CODING: assert property (@(posedge clock)
    disable iff (!arst_n)
    clk_en && run && strobe_rise && style == AOC_STYLE_LVDS
    |=> diff_data_word[AOC_MSB]
        == ($past(result[AOC_MSB]) ^ !$past(twos_fmt)))
    else $error("MSB coding wrong for format");
  AST_LVDS_STROBE: assert property (@(posedge clock)
    disable iff (!arst_n)
    clk_en && run && strobe_rise && style == AOC_STYLE_LVDS
    |=> diff_valid_strobe)
    else $error("LVDS strobe did not rise with data");
  AST_DEMUX_ALT: assert property (@(posedge clock)
    disable iff (!arst_n)
    clk_en && run && strobe_rise && style == AOC_STYLE_SIMUL
    |=> phase_reg != $past(phase_reg))
    else $error("demux phase did not alternate");
  AST_SIMUL_SETUP: assert property (@(posedge clock)
    disable iff (!arst_n)
    style == AOC_STYLE_SIMUL && $rose(second_bus_valid_strobe)
    |-> $stable(second_bus_word))
    else $error("second word moved as its strobe rose");
endmodule : aoc_ctrl

/* design/aoc_pkg.sv */
// Purpose: shared constants for the converter output control block
// Assumes: four-level straps arrive already quantised to 2-bit codes
// Notes:   aoc_ctrl and the verif files import this package whole; aoc_sync does not
package aoc_pkg;
  localparam int          AOC_WORD_W    = 12;
  localparam int          AOC_MSB       = 11;
  localparam int          AOC_LATENCY   = 5;
  localparam logic [1:0]  AOC_LVL_GND   = 2'h0;
  localparam logic [1:0]  AOC_LVL_THIRD = 2'h1;
  localparam logic [1:0]  AOC_LVL_TWO3  = 2'h2;
  localparam logic [1:0]  AOC_LVL_FULL  = 2'h3;
  localparam logic [11:0] AOC_WORD_RST  = 12'h000;

  typedef enum logic [1:0] {
    AOC_STYLE_FULL  = 2'h0,
    AOC_STYLE_SIMUL = 2'h1,
    AOC_STYLE_INTLV = 2'h3,
    AOC_STYLE_LVDS  = 2'h2
  } aoc_style_type;

  typedef enum logic [1:0] {
    AOC_PWR_RUN   = 2'h0,
    AOC_PWR_HIZ   = 2'h1,
    AOC_PWR_SLEEP = 2'h3,
    AOC_PWR_NAP   = 2'h2
  } aoc_power_type;
endpackage : aoc_pkg

/* design/aoc_sync.sv */
// Purpose: two-flop synchroniser for a bundle of asynchronous inputs
// Assumes: multi-bit inputs are quasi-static straps
// Notes:   first stage is read only by the second stage
`timescale 1ns/10ps
module aoc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : aoc_sync

/* verif/aoc_rx_model.sv */
// Purpose: downstream capture logic model for the converter outputs
// Assumes: strobes are registered levels; capture on their falling edge, simultaneous second bus on its rising edge
// Notes:   demux second bus latched per update style, in sample order
`timescale 1ns/10ps
module aoc_rx_model
  import aoc_pkg::*;
(
  input  wire logic                  lvds_mode,
  input  wire logic                  demux_mode,
  input  wire logic                  simul_mode,
  input  wire logic [AOC_WORD_W-1:0] cmos_word,
  input  wire logic                  cmos_flag,
  input  wire logic                  cmos_strobe,
  input  wire logic [AOC_WORD_W-1:0] pair_word,
  input  wire logic                  pair_flag,
  input  wire logic                  pair_strobe,
  input  wire logic [AOC_WORD_W-1:0] diff_word,
  input  wire logic                  diff_flag,
  input  wire logic                  diff_strobe,
  output logic      [AOC_WORD_W-1:0] cap_word,
  output logic                       cap_flag,
  output logic      [15:0]           cap_count
);
  initial cap_count = 16'h0000;
  always @(negedge cmos_strobe) begin
    if (!lvds_mode) begin
      cap_word = cmos_word;
      cap_flag = cmos_flag;
      cap_count = cap_count + 16'h0001;
    end
  end
  // Second bus: interleaved latches on the fall, simultaneous on the rise
  always @(negedge pair_strobe) begin
    if (demux_mode && !simul_mode) begin
      cap_word = pair_word;
      cap_flag = pair_flag;
      cap_count = cap_count + 16'h0001;
    end
  end
  always @(posedge pair_strobe) begin
    if (demux_mode && simul_mode) begin
      cap_word = pair_word;
      cap_flag = pair_flag;
      cap_count = cap_count + 16'h0001;
    end
  end
  always @(negedge diff_strobe) begin
    if (lvds_mode) begin
      cap_word = diff_word;
      cap_flag = diff_flag;
      cap_count = cap_count + 16'h0001;
    end
  end
endmodule : aoc_rx_model

/* verif/testbench.sv */
// Purpose: self-checking bench for the converter output control block
// Assumes: sampling strobe period 8 clocks, straps static per phase
// Notes:   driver queues expected words; watcher compares on capture
`timescale 1ns/10ps
module testbench;
  import aoc_pkg::*;
  logic        clock, arst_n, strobe, pds, gate, ovr, en;
  logic [1:0]  style, fmt;
  logic [11:0] word;
  logic [12:0] exp_q[$];
  int          mismatches, cmp_count, skip, seed;
  wire  [11:0] fw, sw, dw, cap_word;
  wire         fwo, ff, fs, fo, sf, ss, swo, sso, df, ds, doe, stab, conv;
  wire         cap_flag;
  wire  [15:0] cap_count;

  aoc_ctrl #(.LATENCY(AOC_LATENCY)) u_dut (
    .clock(clock), .arst_n(arst_n), .clk_en(en),
    .sample_strobe_p(strobe), .sample_strobe_n(~strobe),
    .power_down_select(pds), .drive_gate(gate), .style_strap(style),
    .format_strap(fmt), .sample_word(word), .sample_over_range(ovr),
    .first_bus_word(fw), .first_bus_word_oe_n(fwo),
    .first_bus_range_flag(ff), .first_bus_valid_strobe(fs),
    .first_bus_oe_n(fo), .second_bus_word(sw),
    .second_bus_range_flag(sf), .second_bus_valid_strobe(ss),
    .second_bus_word_oe_n(swo), .second_bus_strobe_oe_n(sso),
    .diff_data_word(dw), .diff_range_flag(df), .diff_valid_strobe(ds),
    .diff_oe_n(doe), .stabiliser_on(stab), .converting(conv));

  aoc_rx_model u_rx (
    .lvds_mode(style == 2'h3), .demux_mode(style == 2'h1 || style == 2'h2),
    .simul_mode(style == 2'h1), .cmos_word(fw), .cmos_flag(ff),
    .cmos_strobe(fs), .pair_word(sw), .pair_flag(sf), .pair_strobe(ss),
    .diff_word(dw), .diff_flag(df), .diff_strobe(ds),
    .cap_word(cap_word), .cap_flag(cap_flag), .cap_count(cap_count));

  task automatic check(input logic [12:0] seen, input logic [12:0] expv);
    cmp_count++;
    if (seen !== expv) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, expv);
    end
  endtask : check

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  // Each phase restarts from reset so no word of an old format leaks in
  task automatic phase(input logic [1:0] st, input logic [1:0] fm);
    logic [11:0] w;
    logic        o;
    exp_q.delete();
    arst_n <= 1'b0;
    style <= st;
    fmt <= fm;
    repeat (2) @(posedge clock);
    skip = AOC_LATENCY;
    arst_n <= 1'b1;
    repeat (4) @(posedge clock);
    check({12'h0, stab}, {12'h0, fm == 2'h1 || fm == 2'h2});
    check({12'h0, doe}, {12'h0, st != 2'h3});
    check({11'h0, fwo, fo}, {11'h0, {2{st == 2'h3}}});
    for (int i = 0; i < 17; i++) begin
      w = (i == 0) ? 12'h000 : (i == 1) ? 12'hfff : 12'($random(seed));
      o = 1'($random(seed));
      word <= w;
      ovr <= o;
      exp_q.push_back({o, fm[1] ? w : {~w[11], w[10:0]}});
      strobe <= 1'b1;
      repeat (4) @(posedge clock);
      if (st != 2'h3) begin
        check({11'h0, swo, sso}, {11'h0, st == 2'h0, 1'b0});
      end
      strobe <= 1'b0;
      repeat (4) @(posedge clock);
    end
    repeat (8) @(posedge clock);
    // Demux leaves the last first-bus word unlatched: one more left over
    w = 12'(AOC_LATENCY + (st == 2'h1 || st == 2'h2));
    check(13'(exp_q.size()), {1'b0, w});
  endtask : phase

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Captures during reset or pipeline fill carry no queued sample
  initial begin
    forever begin
      @(cap_count);
      #1;
      if (!arst_n) continue;
      if (skip > 0) skip--;
      else if (exp_q.size() == 0) check(13'h0, 13'h1fff);
      else check({cap_flag, cap_word}, exp_q.pop_front());
    end
  end

  initial begin
    #200000;
    mismatches++;
    report_and_stop();
  end

  initial begin
    seed = 28308;
    arst_n = 1'b0;
    strobe = 1'b0;
    pds = 1'b0;
    gate = 1'b0;
    style = 2'h0;
    fmt = 2'h0;
    word = 12'h000;
    ovr = 1'b0;
    en = 1'b1;
    phase(2'h0, 2'h0);
    phase(2'h0, 2'h1);
    phase(2'h1, 2'h2);
    phase(2'h2, 2'h0);
    phase(2'h3, 2'h2);
    phase(2'h3, 2'h3);
    // With the enable low a nap request must not get through
    en <= 1'b0;
    pds <= 1'b1;
    repeat (5) @(posedge clock);
    check({12'h0, conv}, 13'h001);
    en <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      pds <= p[1];
      gate <= p[0];
      repeat (5) @(posedge clock);
      check({11'h0, conv, doe}, {11'h0, ~p[1], p != 0});
    end
    report_and_stop();
  end
endmodule : testbench
